//--- design/tpt_pkg.sv
// Constants, register map and helpers of the period timer
package tpt_pkg;

  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_COUNT    = 8'h04;
  localparam logic [7:0] OFS_PERIOD   = 8'h08;
  localparam logic [7:0] OFS_FLAGS    = 8'h0c;
  localparam logic [7:0] OFS_CLEAR    = 8'h10;
  localparam logic [7:0] OFS_ENABLES  = 8'h14;
  localparam logic [7:0] OFS_PRIORITY = 8'h18;

  // Control register layout
  localparam int unsigned CTRL_PRESC_LSB = 0;
  localparam int unsigned CTRL_PRESC_MSB = 1;
  localparam int unsigned CTRL_RUN_BIT   = 2;
  localparam int unsigned CTRL_POST_LSB  = 3;
  localparam int unsigned CTRL_POST_MSB  = 6;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'h7f;

  // Timer bit within the flag, clear, enable and priority registers
  localparam int unsigned FLAG_BIT = 1;

  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;

  // Instruction clock is the reference clock divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

  // Last prescaler state for each divide ratio
  localparam logic [3:0] PRESC_LAST_1  = 4'h0;
  localparam logic [3:0] PRESC_LAST_4  = 4'h3;
  localparam logic [3:0] PRESC_LAST_16 = 4'hf;
  localparam logic [1:0] PRESC_SEL_1   = 2'h0;
  localparam logic [1:0] PRESC_SEL_4   = 2'h1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Prescaler terminal state from the select code; 1x means 16
  function automatic logic [3:0] tpt_presc_last(input logic [1:0] sel);
    case (sel)
      PRESC_SEL_1: tpt_presc_last = PRESC_LAST_1;
      PRESC_SEL_4: tpt_presc_last = PRESC_LAST_4;
      default:     tpt_presc_last = PRESC_LAST_16;
    endcase
  endfunction

  // Register offset from a bus address; upper bits are not decoded
  function automatic logic [7:0] tpt_ofs(input logic [DATA_W-1:0] addr);
    tpt_ofs = addr[7:0];
  endfunction

endpackage

//--- design/tpt_core_if.sv
// Control and status signals between the register block and the count core
`timescale 1ns/100ps
interface tpt_core_if;
  logic       instr_tick;
  logic       run;
  logic [1:0] presc_sel;
  logic [3:0] post_sel;
  logic       scaler_clr;
  logic       count_wr;
  logic [7:0] count_wdata;
  logic [7:0] period;
  logic [7:0] count;
  logic       match;
  logic       post_event;

  modport ctrl (
    output instr_tick, run, presc_sel, post_sel, scaler_clr,
    output count_wr, count_wdata, period,
    input  count, match, post_event
  );

  modport core (
    input  instr_tick, run, presc_sel, post_sel, scaler_clr,
    input  count_wr, count_wdata, period,
    output count, match, post_event
  );
endinterface

//--- design/tpt_count_core.sv
// Prescaler, count register and postscaler of the period timer
`timescale 1ns/100ps
module tpt_count_core
  import tpt_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Register block side
  tpt_core_if.core  bus
);
  import tpt_pkg::*;

  logic [3:0] presc_reg;
  logic [3:0] post_reg;
  logic [7:0] count_reg;
  logic       match_reg;
  logic       post_event_reg;
  logic       presc_step;
  logic       inc;
  logic       wrap;

  // Timer advances only while running, on an instruction clock tick
  assign presc_step = bus.run && bus.instr_tick;
  assign inc        = presc_step && (presc_reg == tpt_presc_last(bus.presc_sel));
  assign wrap       = inc && (count_reg == bus.period);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_reg <= 4'h0;
    end else if (bus.scaler_clr) begin
      presc_reg <= 4'h0;
    end else if (presc_step) begin
      presc_reg <= inc ? 4'h0 : presc_reg + 4'h1;
    end
  end

  // A software write beats a same-cycle increment
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= COUNT_RST;
    end else if (bus.count_wr) begin
      count_reg <= bus.count_wdata;
    end else if (inc) begin
      count_reg <= wrap ? 8'h00 : count_reg + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= wrap && !bus.count_wr;
    end
  end

  // Postscaler counts registered matches
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      post_reg       <= 4'h0;
      post_event_reg <= 1'b0;
    end else if (bus.scaler_clr) begin
      post_reg       <= 4'h0;
      post_event_reg <= 1'b0;
    end else begin
      post_event_reg <= match_reg && (post_reg == bus.post_sel);
      if (match_reg) begin
        post_reg <= (post_reg == bus.post_sel) ? 4'h0 : post_reg + 4'h1;
      end
    end
  end

  assign bus.count      = count_reg;
  assign bus.match      = match_reg;
  assign bus.post_event = post_event_reg;

endmodule // tpt_count_core

//--- design/tpt_timer.sv
// Period timer top: AHB-Lite register slave, interrupts and count core
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module tpt_timer
  import tpt_pkg::*;
(
  // Clock and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst_n,
  // AHB-Lite slave
  input  wire logic                      i_hsel,
  input  wire logic [tpt_pkg::DATA_W-1:0] i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [2:0]                i_hsize,
  input  wire logic                      i_hready,
  input  wire logic [tpt_pkg::DATA_W-1:0] i_hwdata,
  output logic [tpt_pkg::DATA_W-1:0]     o_hrdata,
  output logic                           o_hreadyout,
  output logic                           o_hresp,
  // Interrupt requests
  output logic                           o_irq,
  output logic                           o_irq_high,
  output logic                           o_irq_low,
  // Serial port and capture/compare time base
  output logic                           o_serial_port_tick,
  output logic [7:0]                     o_timebase_count,
  output logic                           o_timebase_match
);
  import tpt_pkg::*;

  tpt_core_if core_bus ();

  logic [1:0]        div_reg;
  logic [7:0]        ctrl_reg;
  logic [7:0]        period_reg;
  logic              flag_reg;
  logic              enable_reg;
  logic              prio_reg;
  logic              irq_reg;
  logic              irq_high_reg;
  logic              irq_low_reg;
  logic              wr_pend_reg;
  logic [7:0]        wr_ofs_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              addr_phase;
  logic              wr_ctrl;
  logic              wr_count;
  logic              flag_clr;

  // Every transfer is accepted with no wait state
  assign addr_phase  = i_hsel && i_htrans[1] && i_hready;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && i_hwrite;
      if (addr_phase) begin
        wr_ofs_reg <= tpt_ofs(i_haddr);
      end
    end
  end

  assign wr_ctrl  = wr_pend_reg && (wr_ofs_reg == OFS_CONTROL);
  assign wr_count = wr_pend_reg && (wr_ofs_reg == OFS_COUNT);
  assign flag_clr = wr_pend_reg && (wr_ofs_reg == OFS_CLEAR) && i_hwdata[FLAG_BIT];

  // Read data is sampled at the address phase; unmapped offsets read zero
  always_comb begin
    rdata_next = '0;
    case (tpt_ofs(i_haddr))
      OFS_CONTROL:  rdata_next[7:0] = ctrl_reg;
      OFS_COUNT:    rdata_next[7:0] = core_bus.count;
      OFS_PERIOD:   rdata_next[7:0] = period_reg;
      OFS_FLAGS:    rdata_next[FLAG_BIT] = flag_reg;
      OFS_ENABLES:  rdata_next[FLAG_BIT] = enable_reg;
      OFS_PRIORITY: rdata_next[FLAG_BIT] = prio_reg;
      default:      rdata_next = '0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= '0;
    end else if (addr_phase && !i_hwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  // Instruction clock enable; free running so the bus never alters its phase
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= i_hwdata[7:0] & CTRL_WR_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_reg <= PERIOD_RST;
    end else if (wr_pend_reg && (wr_ofs_reg == OFS_PERIOD)) begin
      period_reg <= i_hwdata[7:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_reg <= 1'b0;
      prio_reg   <= 1'b0;
    end else if (wr_pend_reg) begin
      if (wr_ofs_reg == OFS_ENABLES) begin
        enable_reg <= i_hwdata[FLAG_BIT];
      end
      if (wr_ofs_reg == OFS_PRIORITY) begin
        prio_reg <= i_hwdata[FLAG_BIT];
      end
    end
  end

  // A postscaler event in the clearing cycle wins over the clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= 1'b0;
    end else if (core_bus.post_event) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg      <= 1'b0;
      irq_high_reg <= 1'b0;
      irq_low_reg  <= 1'b0;
    end else begin
      irq_reg      <= flag_reg && enable_reg;
      irq_high_reg <= flag_reg && enable_reg && prio_reg;
      irq_low_reg  <= flag_reg && enable_reg && !prio_reg;
    end
  end

  assign o_irq      = irq_reg;
  assign o_irq_high = irq_high_reg;
  assign o_irq_low  = irq_low_reg;

  // Core control; a control write clears scalers but never loads the count
  assign core_bus.instr_tick  = (div_reg == INSTR_DIV_LAST);
  assign core_bus.run         = ctrl_reg[CTRL_RUN_BIT];
  assign core_bus.presc_sel   = ctrl_reg[CTRL_PRESC_MSB:CTRL_PRESC_LSB];
  assign core_bus.post_sel    = ctrl_reg[CTRL_POST_MSB:CTRL_POST_LSB];
  assign core_bus.scaler_clr  = wr_ctrl || wr_count;
  assign core_bus.count_wr    = wr_count;
  assign core_bus.count_wdata = i_hwdata[7:0];
  assign core_bus.period      = period_reg;

  tpt_count_core u_core (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .bus       (core_bus)
  );

  assign o_serial_port_tick = core_bus.match;
  assign o_timebase_count   = core_bus.count;
  assign o_timebase_match   = core_bus.match;

endmodule // tpt_timer

//--- verif/tpt_timer_props.sv
// Port-level assertions of the period timer
`timescale 1ns/100ps
module tpt_timer_props (
  // Clock, reset and bus request
  input wire logic                        i_ref_clk,
  input wire logic                        i_rst_n,
  input wire logic                        i_hsel,
  input wire logic [1:0]                  i_htrans,
  input wire logic                        i_hwrite,
  input wire logic                        i_hready,
  // Observed outputs
  input wire logic [tpt_pkg::DATA_W-1:0]  o_hrdata,
  input wire logic                        o_hreadyout,
  input wire logic                        o_hresp,
  input wire logic                        o_irq,
  input wire logic                        o_irq_high,
  input wire logic                        o_irq_low,
  input wire logic                        o_serial_port_tick,
  input wire logic [7:0]                  o_timebase_count,
  input wire logic                        o_timebase_match
);
  logic [3:0] since_wr;

  // Zero at reset so values from before a reset never look unexplained
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) since_wr <= 4'h0;
    else if (i_hsel && i_htrans[1] && i_hwrite && i_hready) since_wr <= 4'h0;
    else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or not okay");
  a_rdata_upper: assert property (o_hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_tick_spacing: assert property (o_serial_port_tick |=> !o_serial_port_tick [*3])
    else $error("match pulses closer than one instruction cycle");
  a_wrap_zero: assert property (o_serial_port_tick |->
    ##[0:2] (o_timebase_count == 8'h00))
    else $error("match without wrap to zero");
  a_timebase_match: assert property (o_timebase_match == o_serial_port_tick)
    else $error("time base match differs from serial tick");
  a_irq_split: assert property ((o_irq_high | o_irq_low) == o_irq
    && !(o_irq_high && o_irq_low))
    else $error("priority outputs do not split the request");
  a_irq_clear: assert property ($fell(o_irq) |-> since_wr <= 4'h4)
    else $error("request dropped without a write");
  a_count_step: assert property ($changed(o_timebase_count) |->
    o_timebase_count == $past(o_timebase_count) + 8'h1
    || o_timebase_count == 8'h00 || since_wr <= 4'h3)
    else $error("count jumped");

  cover property (o_serial_port_tick);
  cover property ($rose(o_irq_high));
  cover property ($rose(o_irq_low));
endmodule // tpt_timer_props

bind tpt_timer tpt_timer_props u_props (.i_ref_clk, .i_rst_n, .i_hsel, .i_htrans, .i_hwrite,
  .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .o_irq, .o_irq_high, .o_irq_low,
  .o_serial_port_tick, .o_timebase_count, .o_timebase_match);

//--- verif/testbench.sv
// Self-checking bench of the period timer
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  import tpt_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              hsel = 1'b0;
  logic [DATA_W-1:0] haddr = '0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [DATA_W-1:0] hwdata = '0;
  logic [DATA_W-1:0] hrdata;
  logic [DATA_W-1:0] rd_v;
  logic              rdy, resp, irq, irq_hi, irq_lo, tick, pm;
  logic [7:0]        cnt;
  logic [31:0]       seed = 32'h8c56;
  int                mismatches = 0;
  int                total_checks = 0;
  int                mdl [8];
  int                n, d;

  always #4 clk = ~clk;

  tpt_timer dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(rdy), .i_hwdata(hwdata),
    .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp), .o_irq(irq), .o_irq_high(irq_hi),
    .o_irq_low(irq_lo), .o_serial_port_tick(tick), .o_timebase_count(cnt),
    .o_timebase_match(pm));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd_v = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    xfer(a, 1'b1, {24'h0, v});
    if (a == OFS_CONTROL) mdl[0] = v & CTRL_WR_MASK;
    else if (a == OFS_CLEAR) mdl[3] = mdl[3] & ~32'(v);
    else if (a == OFS_ENABLES || a == OFS_PRIORITY) mdl[a >> 2] = v & 8'h02;
    else if (a != OFS_FLAGS) mdl[a >> 2] = v;
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(a, 1'b0, '0);
    `CHK(rd_v, 32'(mdl[a >> 2]))
  endtask

  task automatic chk_rst();
    mdl = '{0, 0, 255, 0, 0, 0, 0, 0};
    for (int i = 0; i < 8; i++) rd(8'(i * 4));
    $display("reset values done");
  endtask

  task automatic gap(output int c);
    c = 0;
    while (tick !== 1'b1) @(posedge clk);
    @(posedge clk);
    while (tick !== 1'b1) begin
      c++;
      @(posedge clk);
    end
    `CHK(pm, 1'b1)
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_rst();
    seed = lfsr(seed);
    wr(OFS_CONTROL, (seed[7:0] & 8'hfb) | 8'h80);
    rd(OFS_CONTROL);
    wr(OFS_COUNT, seed[15:8]);
    wr(OFS_PERIOD, seed[23:16]);
    repeat (40) @(posedge clk);
    rd(OFS_COUNT);
    rd(OFS_PERIOD);
    wr(OFS_CONTROL, 8'h03);
    rd(OFS_COUNT);
    $display("register access done");
    wr(OFS_PERIOD, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CONTROL, 8'(c) | 8'h04);
      gap(d);
      `CHK(d + 1, 12 * (c == 0 ? 1 : c == 1 ? 4 : 16))
    end
    $display("prescale done");
    wr(OFS_ENABLES, 8'h02);
    wr(OFS_PERIOD, 8'h00);
    for (int p = 0; p < 16; p++) begin
      seed = lfsr(seed);
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_PRIORITY, {6'h0, seed[0], 1'b0});
      wr(OFS_CLEAR, 8'h02);
      wr(OFS_CONTROL, 8'(p << 3) | 8'h04);
      n = 0;
      while (irq !== 1'b1) begin
        if (tick === 1'b1) n++;
        @(posedge clk);
      end
      `CHK(n, p + 1)
      mdl[3] = 2;
      wr(OFS_CONTROL, 8'h00);
      repeat (20) @(posedge clk);
      `CHK({irq_hi, irq_lo}, {seed[0], ~seed[0]})
      rd(OFS_FLAGS);
    end
    wr(OFS_ENABLES, 8'h00);
    rd(OFS_FLAGS);
    `CHK(irq, 1'b0)
    wr(OFS_CLEAR, 8'h02);
    wr(OFS_ENABLES, 8'h02);
    rd(OFS_FLAGS);
    `CHK(irq, 1'b0)
    $display("postscale and interrupt done");
    wr(OFS_PERIOD, 8'hff);
    wr(OFS_CONTROL, 8'h06);
    repeat (37) @(posedge clk);
    wr(OFS_COUNT, 8'h10);
    while (cnt !== 8'h10) @(posedge clk);
    d = 0;
    while (cnt === 8'h10) begin
      d++;
      @(posedge clk);
    end
    // Cleared prescaler: 16 ticks, first one 1 to 4 clocks after the write
    `CHK(d >= 61 && d <= 64, 1'b1)
    $display("scaler clear done");
    // Reset in mid-run, with the timer counting
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_rst();
    results();
  end

  // Whole run is near 3150 cycles
  initial begin
    #(8 * 30000);
    mismatches++;
    results();
  end
endmodule // testbench
